// file: shared/touch_scan_pkg.sv
package touch_scan_pkg;
    // Register map (word addresses on the plain port)
    localparam logic [3:0] ADDR_WIDTH_BITS   = 4'h4;
    localparam logic [3:0] CTRL_ADDR         = 4'h0;
    localparam logic [3:0] X_RESULT_ADDR     = 4'h1;
    localparam logic [3:0] Y_RESULT_ADDR     = 4'h2;
    localparam logic [3:0] PRS1_RESULT_ADDR  = 4'h3;
    localparam logic [3:0] PRS2_RESULT_ADDR  = 4'h4;
    localparam logic [3:0] BATT_RESULT_ADDR  = 4'h5;
    localparam logic [3:0] AUXA_RESULT_ADDR  = 4'h6;
    localparam logic [3:0] AUXB_RESULT_ADDR  = 4'h7;

    // Control register fields
    localparam int PEN_BIT       = 15;
    localparam int STATE_BIT     = 14;
    localparam int SCAN_MSB      = 13;
    localparam int SCAN_LSB      = 10;
    localparam int WIDTH_MSB     = 9;
    localparam int WIDTH_LSB     = 8;

    // Scan function codes
    localparam logic [3:0] SCAN_NONE      = 4'h0;
    localparam logic [3:0] SCAN_XY        = 4'h1;
    localparam logic [3:0] SCAN_XYZ       = 4'h2;
    localparam logic [3:0] SCAN_X_ONLY    = 4'h3;
    localparam logic [3:0] SCAN_PORT      = 4'hb;
    localparam logic [3:0] SCAN_DRV_X     = 4'hd;
    localparam logic [3:0] SCAN_DRV_YX    = 4'hf;

    // Width codes
    localparam logic [1:0] WIDTH_12A      = 2'h0;
    localparam logic [1:0] WIDTH_8        = 2'h1;
    localparam logic [1:0] WIDTH_10       = 2'h2;

    // Result slot numbers, one per result register
    localparam logic [2:0] SLOT_X         = 3'h0;
    localparam logic [2:0] SLOT_Y         = 3'h1;
    localparam logic [2:0] SLOT_PRS1      = 3'h2;
    localparam logic [2:0] SLOT_PRS2      = 3'h3;
    localparam logic [2:0] SLOT_BATT      = 3'h4;
    localparam logic [2:0] SLOT_AUXA      = 3'h5;
    localparam logic [2:0] SLOT_AUXB      = 3'h6;
    localparam int         SLOT_COUNT     = 7;

    // Reset values
    localparam logic [15:0] RESULT_RESET  = 16'h0000;
    localparam logic [3:0]  SCAN_RESET    = 4'h0;
    localparam logic [1:0]  WIDTH_RESET   = 2'h0;

    // Analog channel select codes on the converter port
    localparam logic [2:0] CHAN_X         = 3'h0;
    localparam logic [2:0] CHAN_Y         = 3'h1;
    localparam logic [2:0] CHAN_PRS1      = 3'h2;
    localparam logic [2:0] CHAN_PRS2      = 3'h3;
    localparam logic [2:0] CHAN_BATT      = 3'h4;
    localparam logic [2:0] CHAN_AUXA      = 3'h5;
    localparam logic [2:0] CHAN_AUXB      = 3'h6;
endpackage

// file: hw/result_store.sv
`timescale 1ns/1ns
// Seven result words, written by the sequencer, read by the host port
module result_store
    import touch_scan_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Write side
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_slot,
    input  wire logic [11:0] wr_data,
    // Read side
    input  wire logic [2:0]  rd_slot,
    output logic      [15:0] rd_data
);
    logic [11:0] word_reg [SLOT_COUNT];

    // One holding word per slot, cleared by reset
    genvar g;
    generate
        for (g = 0; g < SLOT_COUNT; g++) begin : g_word
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    word_reg[g] <= RESULT_RESET[11:0];
                end else if (wr_en && wr_slot == 3'(g)) begin
                    word_reg[g] <= wr_data;
                end
            end
        end
    endgenerate

    // Registered read; upper nibble always zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_data <= RESULT_RESET;
        end else if (int'(rd_slot) < SLOT_COUNT) begin
            rd_data <= {4'h0, word_reg[rd_slot]};
        end else begin
            rd_data <= RESULT_RESET;
        end
    end
endmodule

// file: hw/touch_scan_ctrl.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
module touch_scan_ctrl
    import touch_scan_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [15:0] reg_rdata,
    // Pen detect pin, asynchronous
    input  wire logic        pen_touch,
    // Converter core handshake
    output logic             conv_start,
    output logic      [2:0]  conv_channel,
    output logic      [1:0]  conv_width,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_data,
    // Panel drivers and power
    output logic             x_plus_drive,
    output logic             x_minus_drive,
    output logic             y_plus_drive,
    output logic             y_minus_drive,
    output logic             converter_power_down
);
    typedef enum logic [1:0] {IDLE, START, WAIT} seq_type;

    seq_type     seq_reg;
    logic        pen_meta_reg;
    logic        pen_sync_reg;
    logic        pen_state_ctrl_mode_reg;
    logic        converter_state_stop_reg;
    logic [3:0]  scan_function_select_reg;
    logic [1:0]  conversion_width_select_reg;
    logic [2:0]  step_reg;
    logic [2:0]  step_next;
    logic        ctrl_rd_reg;
    logic [15:0] ctrl_rdata_reg;
    logic [15:0] store_rdata;
    logic        store_wr;
    logic [2:0]  store_slot;
    logic [2:0]  rd_slot;
    logic        ctrl_write;
    logic        scan_active;
    logic        repeat_scan;
    logic        pen_needed;
    logic        last_step;
    logic [2:0]  step_channel;
    logic [2:0]  step_slot;
    logic        done_taken;

    // All checks below sample on the one clock and rest during reset
    default clocking assert_clk @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    assign ctrl_write = reg_write && reg_addr == CTRL_ADDR;

    // Pen pin crosses into this domain through two flops
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pen_meta_reg <= 1'b0;
            pen_sync_reg <= 1'b0;
        end else begin
            pen_meta_reg <= pen_touch;
            pen_sync_reg <= pen_meta_reg;
        end
    end

    // Writable control fields; result registers have no write path
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pen_state_ctrl_mode_reg     <= 1'b0;
            converter_state_stop_reg    <= 1'b0;
            scan_function_select_reg    <= SCAN_RESET;
            conversion_width_select_reg <= WIDTH_RESET;
        end else if (ctrl_write) begin
            pen_state_ctrl_mode_reg     <= reg_wdata[PEN_BIT];
            converter_state_stop_reg    <= reg_wdata[STATE_BIT];
            scan_function_select_reg    <= reg_wdata[SCAN_MSB:SCAN_LSB];
            conversion_width_select_reg <= reg_wdata[WIDTH_MSB:WIDTH_LSB];
        end
    end

    // Per-step channel and slot for each scan code
    always_comb begin
        step_channel = CHAN_X;
        step_slot    = SLOT_X;
        last_step    = 1'b1;
        unique case (scan_function_select_reg)
            SCAN_XY: begin
                step_channel = step_reg[0] ? CHAN_Y : CHAN_X;
                step_slot    = step_reg[0] ? SLOT_Y : SLOT_X;
                last_step    = step_reg == 3'h1;
            end
            SCAN_XYZ: begin
                step_channel = step_reg;
                step_slot    = step_reg;
                last_step    = step_reg == 3'h3;
            end
            SCAN_PORT: begin
                step_channel = CHAN_BATT + step_reg;
                step_slot    = SLOT_BATT + step_reg;
                last_step    = step_reg == 3'h2;
            end
            default: begin
                step_channel = CHAN_X;
                step_slot    = SLOT_X;
                last_step    = 1'b1;
            end
        endcase
    end

    // Only the four converting codes start a sequence
    always_comb begin
        scan_active = 1'b0;
        repeat_scan = 1'b0;
        unique case (scan_function_select_reg)
            SCAN_XY, SCAN_XYZ: begin
                scan_active = 1'b1;
                repeat_scan = 1'b1;
            end
            SCAN_X_ONLY, SCAN_PORT: scan_active = 1'b1;
            default: scan_active = 1'b0;
        endcase
    end

    // Touch codes wait for the pen when the device is in charge
    assign pen_needed = repeat_scan || scan_function_select_reg == SCAN_X_ONLY;

    assign step_next = last_step ? 3'h0 : 3'(step_reg + 3'h1);

    // Sequencer: a control write restarts it, stop or pen lift ends it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            seq_reg  <= IDLE;
            step_reg <= 3'h0;
        end else if (ctrl_write) begin
            seq_reg  <= (reg_wdata[STATE_BIT] ||
                         reg_wdata[SCAN_MSB:SCAN_LSB] == SCAN_NONE)
                        ? IDLE : START;
            step_reg <= 3'h0;
        end else if (converter_state_stop_reg) begin
            seq_reg  <= IDLE;
        end else begin
            unique case (seq_reg)
                IDLE: begin
                    // Self-driven mode relaunches touch scans on pen down
                    if (pen_state_ctrl_mode_reg && pen_needed &&
                        scan_active && pen_sync_reg) begin
                        seq_reg  <= START;
                        step_reg <= 3'h0;
                    end
                end
                START: begin
                    if (!scan_active) begin
                        seq_reg <= IDLE;
                    end else if (pen_needed && pen_state_ctrl_mode_reg &&
                                 !pen_sync_reg) begin
                        seq_reg <= IDLE;
                    end else begin
                        seq_reg <= WAIT;
                    end
                end
                WAIT: begin
                    if (done_taken) begin
                        step_reg <= step_next;
                        if (!last_step) begin
                            seq_reg <= START;
                        end else if (repeat_scan && pen_sync_reg) begin
                            seq_reg <= START;
                        end else begin
                            seq_reg <= IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Converter core strobes, all from flops
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            conv_start           <= 1'b0;
            conv_channel         <= CHAN_X;
            conv_width           <= WIDTH_12A;
            converter_power_down <= 1'b0;
        end else begin
            conv_start <= seq_reg == START && scan_active &&
                          !converter_state_stop_reg && !ctrl_write &&
                          !(pen_needed && pen_state_ctrl_mode_reg &&
                            !pen_sync_reg);
            conv_channel         <= step_channel;
            conv_width           <= conversion_width_select_reg;
            converter_power_down <= converter_state_stop_reg;
        end
    end

    // A done seen while our start strobe is still up belongs to a
    // conversion that a restart abandoned, so it is not taken
    assign done_taken = seq_reg == WAIT && conv_done && !conv_start;

    // Result write; low bits trimmed to the chosen width
    assign store_wr   = done_taken &&
                        !converter_state_stop_reg && !ctrl_write;
    assign store_slot = step_slot;

    // Panel drivers follow the drive codes only
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            x_plus_drive  <= 1'b0;
            x_minus_drive <= 1'b0;
            y_plus_drive  <= 1'b0;
            y_minus_drive <= 1'b0;
        end else begin
            x_plus_drive  <= scan_function_select_reg == SCAN_DRV_X;
            x_minus_drive <= scan_function_select_reg == SCAN_DRV_X ||
                             scan_function_select_reg == SCAN_DRV_YX;
            y_plus_drive  <= scan_function_select_reg == SCAN_DRV_YX;
            y_minus_drive <= 1'b0;
        end
    end

    // Lower widths keep the top bits of the sample, right-justified
    logic [11:0] trimmed;
    always_comb begin
        unique case (conversion_width_select_reg)
            WIDTH_8:  trimmed = {4'h0, conv_data[11:4]};
            WIDTH_10: trimmed = {2'h0, conv_data[11:2]};
            default:  trimmed = conv_data;
        endcase
    end

    assign rd_slot = 3'(reg_addr - X_RESULT_ADDR);

    result_store u_store (
        .ref_clk (ref_clk),
        .rst     (rst),
        .wr_en   (store_wr),
        .wr_slot (store_slot),
        .wr_data (trimmed),
        .rd_slot (rd_slot),
        .rd_data (store_rdata)
    );

    // Control read image: live pen and idle flag (one when idle) in the top bits
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_rd_reg    <= 1'b0;
            ctrl_rdata_reg <= 16'h0000;
        end else begin
            ctrl_rd_reg    <= reg_read && reg_addr == CTRL_ADDR;
            ctrl_rdata_reg <= {pen_sync_reg,
                               seq_reg == IDLE,
                               scan_function_select_reg,
                               conversion_width_select_reg, 8'h00};
        end
    end

    // Read data mux; unmapped addresses read zero
    logic rd_hit_reg;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_hit_reg <= 1'b0;
        end else begin
            rd_hit_reg <= reg_read && reg_addr >= X_RESULT_ADDR &&
                          reg_addr <= AUXB_RESULT_ADDR;
        end
    end

    // Both sources are flops; the memory read is registered inside the store
    always_comb begin
        reg_rdata = 16'h0000;
        if (ctrl_rd_reg) begin
            reg_rdata = ctrl_rdata_reg;
        end else if (rd_hit_reg) begin
            reg_rdata = store_rdata;
        end
    end

    // Stop forces idle at once; the power-down flop follows a cycle later
    sequence halt_then_power_down;
        seq_reg == IDLE ##1 converter_power_down;
    endsequence

    chk_idle_reads_one: assert property (
        reg_read && reg_addr == CTRL_ADDR && seq_reg == IDLE
        |=> reg_rdata[STATE_BIT])
        else $error("idle state not read as one");

    chk_stop_halts_seq: assert property (
        ctrl_write && reg_wdata[STATE_BIT] |=> halt_then_power_down)
        else $error("stop did not halt");

    chk_power_resumes: assert property (
        ctrl_write && !reg_wdata[STATE_BIT] |=> ##1 !converter_power_down)
        else $error("power down not released");

    chk_drive_x_pair: assert property (
        scan_function_select_reg == SCAN_DRV_X
        |=> x_plus_drive && x_minus_drive && !y_plus_drive)
        else $error("x drivers wrong");

    chk_drive_yx_pair: assert property (
        scan_function_select_reg == SCAN_DRV_YX
        |=> y_plus_drive && x_minus_drive && !x_plus_drive)
        else $error("y x drivers wrong");

    chk_none_no_start: assert property (
        scan_function_select_reg == SCAN_NONE && $stable(seq_reg)
        |=> !conv_start)
        else $error("start with no scan");

    chk_pen_read_back: assert property (
        reg_read && reg_addr == CTRL_ADDR
        |=> reg_rdata[PEN_BIT] == $past(pen_sync_reg))
        else $error("pen state mismatch");

    chk_width_follow: assert property (
        ctrl_write
        |=> ##1 conv_width == $past(reg_wdata[WIDTH_MSB:WIDTH_LSB], 2))
        else $error("width not applied");

    chk_upper_zero: assert property (
        $past(rd_hit_reg) == 1'b0 && rd_hit_reg
        |-> reg_rdata[15:12] == 4'h0)
        else $error("upper bits not zero");
endmodule

// file: sim/conv_core_model.sv
`timescale 1ns/1ns
// Converter core stand-in on the far side of the sequencer
module conv_core_model
    import touch_scan_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Handshake with the controller
    input  wire logic        conv_start,
    input  wire logic [2:0]  conv_channel,
    input  wire logic        power_down,
    output logic             conv_done,
    output logic      [11:0] conv_data
);
    logic [2:0] chan_reg;
    logic [2:0] wait_reg;
    logic       busy_reg;
    logic       slow_reg;

    // Answers alternate prompt and slow; data is scrambled outside done
    // so a stale sample never looks right. Power-down kills a conversion.
    always_ff @(posedge ref_clk) begin
        conv_done <= 1'b0;
        conv_data <= ~conv_data;
        if (rst || power_down) begin
            busy_reg  <= 1'b0;
            slow_reg  <= 1'b0;
            conv_data <= 12'h000;
        end else if (conv_start) begin
            busy_reg <= 1'b1;
            chan_reg <= conv_channel;
            wait_reg <= slow_reg ? 3'h5 : 3'h0;
            slow_reg <= ~slow_reg;
        end else if (busy_reg && wait_reg != 3'h0) begin
            wait_reg <= wait_reg - 3'h1;
        end else if (busy_reg) begin
            busy_reg  <= 1'b0;
            conv_done <= 1'b1;
            conv_data <= {chan_reg + 3'h1, 9'h0a5};
        end
    end
endmodule

// file: sim/test_touch_scan_ctrl.sv
`timescale 1ns/1ns
// Register-level test of the touch scan controller
module test_touch_scan_ctrl
    import touch_scan_pkg::*;
;
    logic        ref_clk;
    logic        rst;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [15:0] reg_rdata;
    logic        pen_touch;
    logic        conv_start;
    logic [2:0]  conv_channel;
    logic [1:0]  conv_width;
    logic        conv_done;
    logic [11:0] conv_data;
    logic        x_plus_drive;
    logic        x_minus_drive;
    logic        y_plus_drive;
    logic        y_minus_drive;
    logic        converter_power_down;
    int          err_count = 0;
    int          cmp_count = 0;
    int          done_cnt = 0;
    int          start_cnt = 0;
    int          n;

    touch_scan_ctrl dut (
        .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .pen_touch, .conv_start, .conv_channel, .conv_width,
        .conv_done, .conv_data, .x_plus_drive, .x_minus_drive,
        .y_plus_drive, .y_minus_drive, .converter_power_down
    );

    conv_core_model core (
        .ref_clk, .rst, .conv_start, .conv_channel,
        .power_down(converter_power_down), .conv_done, .conv_data
    );

    // 25 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Count handshake pulses seen on the core side
    always @(posedge ref_clk) begin
        if (conv_done === 1'b1)
            done_cnt++;
        if (conv_start === 1'b1)
            start_cnt++;
    end

    // Expected result word for a channel at a width code
    function automatic logic [15:0] res(input logic [2:0] ch,
                                        input logic [1:0] w);
        logic [11:0] v;
        v = {ch + 3'h1, 9'h0a5};
        case (w)
            2'h1: return {8'h00, v[11:4]};
            2'h2: return {6'h00, v[11:2]};
            default: return {4'h0, v};
        endcase
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        @(negedge ref_clk);
        check(reg_rdata, exp);
    endtask

    // Bounded wait for a number of finished conversions
    task automatic wait_convs(input int k);
        int target;
        target = done_cnt + k;
        for (int i = 0; i < 400 && done_cnt < target; i++)
            @(posedge ref_clk);
        check(16'(done_cnt >= target), 16'h0001);
        repeat (3) @(posedge ref_clk);
    endtask

    // Driver pattern {x+, x-, y+, y-} and no conversion launched
    task automatic drv_chk(input logic [15:0] v, input logic [15:0] exp);
        int s;
        s = start_cnt;
        reg_wr(CTRL_ADDR, v);
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        check({12'h000, x_plus_drive, x_minus_drive, y_plus_drive,
               y_minus_drive}, exp);
        check(16'(start_cnt - s), 16'h0000);
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog, well beyond the length of the sequence below
    initial begin
        #(40 * 20000);
        err_count++;
        end_of_test();
    end

    // Main sequence
    initial begin
        rst       = 1'b1;
        reg_addr  = 4'h0;
        reg_wdata = 16'h0000;
        reg_write = 1'b0;
        reg_read  = 1'b0;
        pen_touch = 1'b0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        reg_rd(CTRL_ADDR, 16'h4000);
        for (int a = 1; a < 8; a++) begin
            reg_wr(4'(a), 16'hffff);
            reg_rd(4'(a), RESULT_RESET);
        end
        reg_rd(4'h9, 16'h0000);
        drv_chk(16'h0000, 16'h0000);
        check({15'h0, converter_power_down}, 16'h0000);
        // Host-driven scans with the pen down
        @(posedge ref_clk);
        pen_touch <= 1'b1;
        reg_wr(CTRL_ADDR, 16'h0400);
        wait_convs(4);
        reg_rd(CTRL_ADDR, 16'h8400);
        reg_rd(X_RESULT_ADDR, res(CHAN_X, 2'h0));
        reg_rd(Y_RESULT_ADDR, res(CHAN_Y, 2'h0));
        reg_wr(CTRL_ADDR, 16'h0800);
        wait_convs(8);
        reg_rd(PRS1_RESULT_ADDR, res(CHAN_PRS1, 2'h0));
        reg_rd(PRS2_RESULT_ADDR, res(CHAN_PRS2, 2'h0));
        // Stop in mid-scan, then back to normal operation
        reg_wr(CTRL_ADDR, 16'h4800);
        repeat (3) @(posedge ref_clk);
        n = start_cnt;
        @(negedge ref_clk);
        check({15'h0, converter_power_down}, 16'h0001);
        repeat (20) @(posedge ref_clk);
        check(16'(start_cnt - n), 16'h0000);
        reg_rd(CTRL_ADDR, 16'hc800);
        reg_wr(CTRL_ADDR, 16'h0000);
        // The power-down pin follows the stop field one cycle later
        repeat (2) @(negedge ref_clk);
        check({15'h0, converter_power_down}, 16'h0000);
        // X-only conversion at every width code
        for (int w = 0; w < 4; w++) begin
            reg_wr(CTRL_ADDR, 16'h0c00 | 16'(w << 8));
            wait_convs(1);
            check({14'h0, conv_width}, 16'(w));
            reg_rd(X_RESULT_ADDR, res(CHAN_X, 2'(w)));
            reg_rd(CTRL_ADDR, 16'hcc00 | 16'(w << 8));
        end
        reg_wr(CTRL_ADDR, 16'h2c00);
        wait_convs(3);
        reg_rd(BATT_RESULT_ADDR, res(CHAN_BATT, 2'h0));
        reg_rd(AUXA_RESULT_ADDR, res(CHAN_AUXA, 2'h0));
        reg_rd(AUXB_RESULT_ADDR, res(CHAN_AUXB, 2'h0));
        drv_chk(16'h3400, 16'h000c);
        drv_chk(16'h3c00, 16'h0006);
        drv_chk(16'h0000, 16'h0000);
        // Pen lift ends a repeating scan
        reg_wr(CTRL_ADDR, 16'h0400);
        wait_convs(2);
        pen_touch <= 1'b0;
        repeat (30) @(posedge ref_clk);
        reg_rd(CTRL_ADDR, 16'h4400);
        // Self-driven mode holds off until the pen comes down
        n = start_cnt;
        reg_wr(CTRL_ADDR, 16'h8400);
        repeat (20) @(posedge ref_clk);
        check(16'(start_cnt - n), 16'h0000);
        pen_touch <= 1'b1;
        wait_convs(2);
        reg_rd(CTRL_ADDR, 16'h8400);
        end_of_test();
    end
endmodule
